// [common/ipc_pkg.sv]
// Shared constants, register map and level encoding for the interrupt priority control block.
package ipc_pkg;

   // Register indices; the byte address on the bus is four times the index.
   localparam logic [7:0] IPC_IDX_CONTROL = 8'h00;  // Control register index.
   localparam logic [7:0] IPC_IDX_STATUS  = 8'h01;  // Executing-level status index.
   localparam logic [7:0] IPC_IDX_BASE    = 8'h02;  // Normal-priority base index.
   localparam logic [7:0] IPC_IDX_HIGHVEC = 8'h03;  // High-priority vector index.

   // Bus address width and the byte stride between registers.
   localparam int         IPC_ADDR_W      = 8;      // Byte address width.
   localparam int         IPC_STRIDE      = 4;      // Bytes per register word.

   // Control register field positions.
   localparam int         IPC_CTL_VECSEL  = 6;      // Vector location select bit.
   localparam int         IPC_CTL_COMPACT = 5;      // Compact table enable bit.
   localparam int         IPC_CTL_RROBIN  = 0;      // Round robin enable bit.

   // Status register field positions.
   localparam int         IPC_STS_NMI     = 7;      // Non-maskable executing bit.
   localparam int         IPC_STS_HIGH    = 1;      // High level executing bit.
   localparam int         IPC_STS_NORMAL  = 0;      // Normal level executing bit.

   // Reset values of every writable register.
   localparam logic [7:0] IPC_RST_CONTROL = 8'h00;  // Control reset value.
   localparam logic [7:0] IPC_RST_BASE    = 8'h00;  // Priority base reset value.
   localparam logic [7:0] IPC_RST_HIGHVEC = 8'h00;  // High vector reset value.

   // Vector map: vector 0 is reset, vector 1 is the non-maskable source.
   localparam int         IPC_NUM_VEC     = 64;     // Number of vectors in the table.
   localparam logic [7:0] IPC_VEC_RESET   = 8'h00;  // Reset vector number.
   localparam logic [7:0] IPC_VEC_NMI     = 8'h01;  // Non-maskable vector number.
   localparam logic [7:0] IPC_CVT_NMI     = 8'h01;  // Compact table slot for NMI.
   localparam logic [7:0] IPC_CVT_HIGH    = 8'h02;  // Compact table slot for high level.
   localparam logic [7:0] IPC_CVT_NORMAL  = 8'h03;  // Compact table slot for normal level.
   localparam logic [15:0] IPC_RESET_PC   = 16'h0000; // Program counter after reset.

   // AXI response codes.
   localparam logic [1:0] IPC_RESP_OKAY   = 2'b00;  // Normal completion.
   localparam logic [1:0] IPC_RESP_SLVERR = 2'b10;  // Unmapped address.

   // Priority level of an interrupt being taken.
   typedef enum logic [1:0] {
      IPC_LVL_NORMAL = 2'b00,
      IPC_LVL_HIGH   = 2'b01,
      IPC_LVL_NMI    = 2'b10
   } ipc_level_type;

endpackage

// [src/ipc_wrap_arbiter.sv]
// Wrap-around priority picker for normal-priority vectors.
`timescale 1ns/1ps
module ipc_wrap_arbiter
   import ipc_pkg::*;
(
   input  wire logic [IPC_NUM_VEC-1:0] pending_in,   // Normal requests by vector number.
   input  wire logic [7:0]             base_in,      // Vector given lowest priority.
   output logic                        found_out,    // Some request is pending.
   output logic [7:0]                  winner_out    // Chosen vector number.
);

   // Scan from base+1 upward, wrapping; the base itself is looked at last.
   // A linear scan costs depth but keeps the order exactly as software sets it.
   always_comb begin
      logic [7:0] idx;
      idx        = 8'h00;
      found_out  = 1'b0;
      winner_out = 8'h00;
      for (int i = 1; i <= IPC_NUM_VEC; i++) begin
         idx = 8'((32'(base_in) + i) % IPC_NUM_VEC);
         if (!found_out && pending_in[idx[5:0]]) begin
            found_out  = 1'b1;
            winner_out = idx;
         end
      end
   end

endmodule

// [src/ipc_level_tracker.sv]
// Tracks which priority levels are executing, set on entry and cleared on return.
`timescale 1ns/1ps
module ipc_level_tracker
   import ipc_pkg::*;
(
   input  wire logic          core_clk_in,     // System clock.
   input  wire logic          resetn_in,       // Synchronous active-low reset.
   input  wire logic          enter_in,        // Interrupt entry pulse.
   input  wire ipc_level_type enter_level_in,  // Level being entered.
   input  wire logic          return_in,       // Interrupt return pulse.
   output logic               nmi_ex_out,      // Non-maskable handler active.
   output logic               high_ex_out,     // High-level handler active or preempted.
   output logic               normal_ex_out    // Normal handler active or preempted.
);

   // All tracker state.
   typedef struct packed {
      logic nmi;
      logic high;
      logic normal;
   } ipc_track_type;

   ipc_track_type st_q;  // Registered state.
   ipc_track_type st_d;  // Next state.

   // A return leaves the innermost level only; outer flags stay set so the
   // preempted handler is still marked as running.
   always_comb begin
      st_d = st_q;
      if (return_in) begin
         if (st_q.nmi) begin
            st_d.nmi = 1'b0;
         end else if (st_q.high) begin
            st_d.high = 1'b0;
         end else begin
            st_d.normal = 1'b0;
         end
      end
      if (enter_in) begin
         unique case (enter_level_in)
            IPC_LVL_NMI:    st_d.nmi    = 1'b1;
            IPC_LVL_HIGH:   st_d.high   = 1'b1;
            IPC_LVL_NORMAL: st_d.normal = 1'b1;
            default:        st_d        = st_d;
         endcase
      end
   end

   // State register with synchronous reset.
   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign nmi_ex_out    = st_q.nmi;
   assign high_ex_out   = st_q.high;
   assign normal_ex_out = st_q.normal;

endmodule

// [src/ipc_interrupt_priority_control.sv]
// Interrupt priority control: AXI4-Lite registers, arbitration and CPU request port.
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
module ipc_interrupt_priority_control
   import ipc_pkg::*;
(
   input  wire logic                   core_clk_in,          // System clock, 250 MHz.
   input  wire logic                   resetn_in,            // Synchronous active-low reset.
   // AXI4-Lite write address channel.
   input  wire logic [IPC_ADDR_W-1:0]  s_axi_awaddr_in,
   input  wire logic [2:0]             s_axi_awprot_in,
   input  wire logic                   s_axi_awvalid_in,
   output logic                        s_axi_awready_out,
   // AXI4-Lite write data channel.
   input  wire logic [31:0]            s_axi_wdata_in,
   input  wire logic [3:0]             s_axi_wstrb_in,
   input  wire logic                   s_axi_wvalid_in,
   output logic                        s_axi_wready_out,
   // AXI4-Lite write response channel.
   output logic [1:0]                  s_axi_bresp_out,
   output logic                        s_axi_bvalid_out,
   input  wire logic                   s_axi_bready_in,
   // AXI4-Lite read address channel.
   input  wire logic [IPC_ADDR_W-1:0]  s_axi_araddr_in,
   input  wire logic [2:0]             s_axi_arprot_in,
   input  wire logic                   s_axi_arvalid_in,
   output logic                        s_axi_arready_out,
   // AXI4-Lite read data channel.
   output logic [31:0]                 s_axi_rdata_out,
   output logic [1:0]                  s_axi_rresp_out,
   output logic                        s_axi_rvalid_out,
   input  wire logic                   s_axi_rready_in,
   // System side.
   input  wire logic                   unlock_in,            // Protected-write unlock open.
   input  wire logic                   boot_whole_flash_in,  // Entire flash is boot section.
   input  wire logic [IPC_NUM_VEC-1:0] irq_req_in,           // Request lines by vector number.
   input  wire logic                   cpu_int_enable_in,    // Global enable for maskable levels.
   input  wire logic                   cpu_ack_in,           // CPU takes the offered request.
   input  wire logic                   cpu_return_in,        // CPU executes interrupt return.
   output logic                        irq_valid_out,        // A request is offered.
   output logic [7:0]                  irq_vector_out,       // Vector the CPU jumps to.
   output logic [7:0]                  irq_source_out,       // Original vector number.
   output logic [1:0]                  irq_level_out,        // Level of the offered request.
   output logic                        vectors_at_boot_out,  // Table at start of boot section.
   output logic [15:0]                 reset_pc_out          // Program counter after reset.
);

   // All registered state of the block apart from the level tracker flags.
   typedef struct packed {
      logic [IPC_ADDR_W-1:0] aw_addr;   // Captured write address.
      logic                  aw_held;   // Write address taken, awaiting data.
      logic [7:0]            w_data;    // Captured low write byte.
      logic                  w_lane;    // Low byte lane was enabled.
      logic                  w_held;    // Write data taken, awaiting address.
      logic                  bvalid;    // Write response pending.
      logic [1:0]            bresp;     // Write response code.
      logic                  rvalid;    // Read data pending.
      logic [1:0]            rresp;     // Read response code.
      logic [7:0]            rdata;     // Read data byte.
      logic                  vecsel;    // Vector location select.
      logic                  compact;   // Compact table enable.
      logic                  rrobin;    // Round robin enable.
      logic [7:0]            base;      // Normal-priority base.
      logic [7:0]            highvec;   // High-priority vector number.
      logic                  offer;     // Request offered to the CPU.
      logic [7:0]            vec;       // Offered jump vector.
      logic [7:0]            src;       // Offered source vector.
      ipc_level_type         lvl;       // Offered level.
   } ipc_state_type;

   ipc_state_type st_q;  // Registered state.
   ipc_state_type st_d;  // Next state.

   // True when a byte address hits an implemented register word.
   function automatic logic addr_hit(input logic [IPC_ADDR_W-1:0] a);
      return (a[1:0] == 2'b00) && (32'(a) / IPC_STRIDE <= 32'(IPC_IDX_HIGHVEC));
   endfunction

   // Register index of a byte address.
   function automatic logic [7:0] addr_index(input logic [IPC_ADDR_W-1:0] a);
      return 8'(32'(a) / IPC_STRIDE);
   endfunction

   // Level tracker outputs.
   logic nmi_ex;
   logic high_ex;
   logic normal_ex;

   // Arbiter results.
   logic       norm_found;
   logic [7:0] norm_winner;

   // Request classification.
   logic [IPC_NUM_VEC-1:0] high_mask;
   logic [IPC_NUM_VEC-1:0] normal_req;
   logic                   nmi_pend;
   logic                   high_pend;
   logic                   normal_pend;
   logic                   high_enabled;
   logic                   take;

   // A high vector of zero names the reset slot, which means no high level.
   assign high_enabled = (st_q.highvec != IPC_VEC_RESET)
                         && (st_q.highvec != IPC_VEC_NMI)
                         && (32'(st_q.highvec) < IPC_NUM_VEC);

   // One-hot mask of the high vector so it drops out of normal arbitration.
   always_comb begin
      high_mask = '0;
      if (high_enabled) begin
         high_mask[st_q.highvec[5:0]] = 1'b1;
      end
   end

   // Normal requests exclude reset, the non-maskable source and the high vector.
   always_comb begin
      normal_req = irq_req_in & ~high_mask;
      normal_req[IPC_VEC_RESET[5:0]] = 1'b0;
      normal_req[IPC_VEC_NMI[5:0]]   = 1'b0;
   end

   // Arbitration among normal requests, starting after the base.
   ipc_wrap_arbiter u_arb (
      .pending_in (normal_req),
      .base_in    (st_q.base),
      .found_out  (norm_found),
      .winner_out (norm_winner)
   );

   // Nothing interrupts an NMI; high preempts normal; normal only when idle.
   assign nmi_pend    = irq_req_in[IPC_VEC_NMI[5:0]] && !nmi_ex;
   assign high_pend   = high_enabled && irq_req_in[st_q.highvec[5:0]]
                        && cpu_int_enable_in && !nmi_ex && !high_ex;
   assign normal_pend = norm_found && cpu_int_enable_in
                        && !nmi_ex && !high_ex && !normal_ex;

   // An acknowledge counts only against a request actually on offer.
   assign take = cpu_ack_in && st_q.offer;

   // Executing-level flags; only entry and return move them.
   ipc_level_tracker u_track (
      .core_clk_in    (core_clk_in),
      .resetn_in      (resetn_in),
      .enter_in       (take),
      .enter_level_in (st_q.lvl),
      .return_in      (cpu_return_in),
      .nmi_ex_out     (nmi_ex),
      .high_ex_out    (high_ex),
      .normal_ex_out  (normal_ex)
   );

   // Next-state logic: bus slave, register writes, and request offering.
   always_comb begin
      logic [7:0] ridx;
      logic [7:0] widx;
      logic [7:0] rbyte;
      ridx  = addr_index(s_axi_araddr_in);
      widx  = addr_index(st_q.aw_addr);
      rbyte = 8'h00;
      st_d  = st_q;

      // Write address and data are taken independently, one of each at a time.
      if (s_axi_awvalid_in && !st_q.aw_held) begin
         st_d.aw_addr = s_axi_awaddr_in;
         st_d.aw_held = 1'b1;
      end
      if (s_axi_wvalid_in && !st_q.w_held) begin
         st_d.w_data = s_axi_wdata_in[7:0];
         st_d.w_lane = s_axi_wstrb_in[0];
         st_d.w_held = 1'b1;
      end

      // Response retires on handshake.
      if (st_q.bvalid && s_axi_bready_in) begin
         st_d.bvalid = 1'b0;
      end

      // Perform the write once both halves are held and no response is waiting.
      if (st_q.aw_held && st_q.w_held && !st_q.bvalid) begin
         st_d.aw_held = 1'b0;
         st_d.w_held  = 1'b0;
         st_d.bvalid  = 1'b1;
         st_d.bresp   = addr_hit(st_q.aw_addr) ? IPC_RESP_OKAY : IPC_RESP_SLVERR;
         if (addr_hit(st_q.aw_addr) && st_q.w_lane) begin
            unique case (widx)
               IPC_IDX_CONTROL: begin
                  // Round robin always writable; the other two need the unlock.
                  st_d.rrobin = st_q.w_data[IPC_CTL_RROBIN];
                  if (unlock_in) begin
                     st_d.vecsel  = st_q.w_data[IPC_CTL_VECSEL];
                     st_d.compact = st_q.w_data[IPC_CTL_COMPACT];
                  end
               end
               IPC_IDX_STATUS: begin
                  st_d.bresp = IPC_RESP_OKAY;
               end
               IPC_IDX_BASE:    st_d.base    = st_q.w_data;
               IPC_IDX_HIGHVEC: st_d.highvec = st_q.w_data;
               default:         st_d.bresp   = IPC_RESP_SLVERR;
            endcase
         end
      end

      // Read channel: one outstanding read, answered the next cycle.
      if (st_q.rvalid && s_axi_rready_in) begin
         st_d.rvalid = 1'b0;
      end
      if (s_axi_arvalid_in && !st_q.rvalid) begin
         unique case (ridx)
            IPC_IDX_CONTROL: begin
               rbyte[IPC_CTL_VECSEL]  = st_q.vecsel;
               rbyte[IPC_CTL_COMPACT] = st_q.compact;
               rbyte[IPC_CTL_RROBIN]  = st_q.rrobin;
            end
            IPC_IDX_STATUS: begin
               rbyte[IPC_STS_NMI]    = nmi_ex;
               rbyte[IPC_STS_HIGH]   = high_ex;
               rbyte[IPC_STS_NORMAL] = normal_ex;
            end
            IPC_IDX_BASE:    rbyte = st_q.base;
            IPC_IDX_HIGHVEC: rbyte = st_q.highvec;
            default:         rbyte = 8'h00;
         endcase
         st_d.rvalid = 1'b1;
         st_d.rdata  = addr_hit(s_axi_araddr_in) ? rbyte : 8'h00;
         st_d.rresp  = addr_hit(s_axi_araddr_in) ? IPC_RESP_OKAY : IPC_RESP_SLVERR;
      end

      // Round robin: the acknowledged normal vector becomes the new base,
      // so it ranks lowest next time. Hardware update wins over a bus write.
      if (take && st_q.lvl == IPC_LVL_NORMAL && st_q.rrobin) begin
         st_d.base = st_q.src;
      end

      // Offer the most urgent request. The offer drops for the cycle after
      // an acknowledge so that the tracker flags are current before re-arbitrating.
      st_d.offer = 1'b0;
      if (!take) begin
         if (nmi_pend) begin
            st_d.offer = 1'b1;
            st_d.lvl   = IPC_LVL_NMI;
            st_d.src   = IPC_VEC_NMI;
            st_d.vec   = st_q.compact ? IPC_CVT_NMI : IPC_VEC_NMI;
         end else if (high_pend) begin
            st_d.offer = 1'b1;
            st_d.lvl   = IPC_LVL_HIGH;
            st_d.src   = st_q.highvec;
            st_d.vec   = st_q.compact ? IPC_CVT_HIGH : st_q.highvec;
         end else if (normal_pend) begin
            // With the base at reset value the lowest vector wins.
            st_d.offer = 1'b1;
            st_d.lvl   = IPC_LVL_NORMAL;
            st_d.src   = norm_winner;
            st_d.vec   = st_q.compact ? IPC_CVT_NORMAL : norm_winner;
         end
      end
   end

   // State register; every field comes out of reset at zero.
   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         st_q         <= '0;
         st_q.vecsel  <= IPC_RST_CONTROL[IPC_CTL_VECSEL];
         st_q.compact <= IPC_RST_CONTROL[IPC_CTL_COMPACT];
         st_q.rrobin  <= IPC_RST_CONTROL[IPC_CTL_RROBIN];
         st_q.base    <= IPC_RST_BASE;
         st_q.highvec <= IPC_RST_HIGHVEC;
         st_q.lvl     <= IPC_LVL_NORMAL;
      end else begin
         st_q <= st_d;
      end
   end

   // Bus handshakes are combinational from the holding flags.
   assign s_axi_awready_out = !st_q.aw_held;
   assign s_axi_wready_out  = !st_q.w_held;
   assign s_axi_bvalid_out  = st_q.bvalid;
   assign s_axi_bresp_out   = st_q.bresp;
   assign s_axi_arready_out = !st_q.rvalid;
   assign s_axi_rvalid_out  = st_q.rvalid;
   assign s_axi_rresp_out   = st_q.rresp;
   assign s_axi_rdata_out   = {24'h000000, st_q.rdata};

   // CPU request port.
   assign irq_valid_out  = st_q.offer;
   assign irq_vector_out = st_q.vec;
   assign irq_source_out = st_q.src;
   assign irq_level_out  = st_q.lvl;

   // The select only matters when the flash is split into boot and application.
   assign vectors_at_boot_out = st_q.vecsel && !boot_whole_flash_in;
   // Reset always starts fetching at zero, whatever the select says.
   assign reset_pc_out        = IPC_RESET_PC;

endmodule

// [verif/ipc_cpu_model.sv]
// CPU core model that acknowledges offers and executes interrupt returns.
`timescale 1ns/1ps
module ipc_cpu_model (
   input  wire logic core_clk_in,
   input  wire logic resetn_in,
   input  wire logic irq_valid_in,
   input  wire logic ack_en_in,
   input  wire logic ret_req_in,
   output logic      cpu_ack_out = 1'h0,
   output logic      cpu_return_out = 1'h0
);
   // Ack is one pulse and only while an offer stands; holding ack_en low acts as a slow core.
   always @(posedge core_clk_in) begin
      cpu_ack_out    <= resetn_in && irq_valid_in && ack_en_in && !cpu_ack_out;
      cpu_return_out <= resetn_in && ret_req_in;
   end
endmodule

// [verif/ipc_ports_sva.sv]
// Port checker for the interrupt priority control block.
`timescale 1ns/1ps
module ipc_ports_sva (
   input wire logic        core_clk_in,
   input wire logic        resetn_in,
   input wire logic        s_axi_arvalid_in,
   input wire logic        s_axi_arready_out,
   input wire logic        s_axi_rvalid_out,
   input wire logic        s_axi_rready_in,
   input wire logic [31:0] s_axi_rdata_out,
   input wire logic        irq_valid_out,
   input wire logic        cpu_ack_in,
   input wire logic [1:0]  irq_level_out,
   input wire logic [7:0]  irq_source_out,
   input wire logic        boot_whole_flash_in,
   input wire logic        vectors_at_boot_out,
   input wire logic [15:0] reset_pc_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!resetn_in);
   // A read answer waiting for the master, and an offer taken by the core.
   sequence r_wait; s_axi_rvalid_out && !s_axi_rready_in; endsequence
   sequence offer_taken; irq_valid_out && cpu_ack_in; endsequence
   boot_ignore_a: assert property (boot_whole_flash_in |-> !vectors_at_boot_out)
      else $error("table select not ignored");
   reset_pc_a: assert property (reset_pc_out == 16'h0000)
      else $error("reset pc not zero");
   rdata_zero_a: assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h000000)
      else $error("upper read bits set");
   read_lat_a: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
      else $error("read answer late");
   r_hold_a: assert property (r_wait |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
      else $error("read answer dropped");
   ack_drop_a: assert property (offer_taken |=> !irq_valid_out)
      else $error("offer kept after ack");
   nmi_src_a: assert property (irq_valid_out && irq_level_out == 2'h2 |-> irq_source_out == 8'h01)
      else $error("wrong nmi source");
   high_src_a: assert property (irq_valid_out && irq_level_out == 2'h1 |->
      irq_source_out > 8'h01 && irq_source_out < 8'h40) else $error("bad high source");
endmodule
bind ipc_interrupt_priority_control ipc_ports_sva i_ipc_ports_sva (.*);

// [verif/ipc_interrupt_priority_control_tb_top.sv]
// Testbench for the interrupt priority control block.
`timescale 1ns/1ps
module ipc_interrupt_priority_control_tb_top
   import ipc_pkg::*;
;
   logic core_clk_in = 1'h0, resetn_in = 1'h0, s_axi_awvalid_in = 1'h0, s_axi_wvalid_in = 1'h0;
   logic s_axi_bready_in = 1'h0, s_axi_arvalid_in = 1'h0, s_axi_rready_in = 1'h0, ack_en = 1'h0;
   logic unlock_in = 1'h0, boot_whole_flash_in = 1'h0, cpu_int_enable_in = 1'h1, ret_req = 1'h0;
   logic [7:0] s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00, irq_vector_out, irq_source_out;
   logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out, d;
   logic [2:0] s_axi_awprot_in = 3'h0, s_axi_arprot_in = 3'h0;
   logic [3:0] s_axi_wstrb_in = 4'hf;
   logic [63:0] irq_req_in = 64'h0;
   logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
   logic s_axi_rvalid_out, irq_valid_out, vectors_at_boot_out, cpu_ack_in, cpu_return_in;
   logic [1:0] s_axi_bresp_out, s_axi_rresp_out, irq_level_out, r;
   logic [15:0] reset_pc_out;
   int fail_count = 0, samples_checked = 0;
   // Rows: address, data, unlock, expected readback, expected response.
   logic [31:0] rows [6] = '{32'h00ff0010, 32'h00ff1610, 32'h08a50a50, 32'h0c3c03c0,
                             32'h04ff0000, 32'h10ff0002};
   logic [7:0] ex [3] = '{8'h03, 8'h01, 8'h00};
   ipc_interrupt_priority_control i_ipc_interrupt_priority_control (.*);
   ipc_cpu_model i_ipc_cpu_model (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
      .irq_valid_in(irq_valid_out), .ack_en_in(ack_en), .ret_req_in(ret_req),
      .cpu_ack_out(cpu_ack_in), .cpu_return_out(cpu_return_in));
   always #2 core_clk_in = ~core_clk_in;
   task final_report;
      $display("checked %0d, wrong %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         fail_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   // A wait that used up its bound ends the run as a failure.
   task tmo(input int i);
      if (i >= 40) begin
         fail_count++;
         final_report;
      end
   endtask
   task clk(input int n);
      repeat (n) @(posedge core_clk_in);
   endtask
   task rst;
      resetn_in <= 1'h0;
      clk(3);
      resetn_in <= 1'h1;
      clk(1);
   endtask
   // Write: address and data offered together, each released when taken.
   task wr(input logic [7:0] a, input logic [7:0] v);
      int i;
      logic ap, wp;
      ap = 1'h1;
      wp = 1'h1;
      s_axi_awaddr_in <= a;
      s_axi_wdata_in <= {24'h0, v};
      s_axi_awvalid_in <= 1'h1;
      s_axi_wvalid_in <= 1'h1;
      s_axi_bready_in <= 1'h1;
      for (i = 0; i < 40 && (ap || wp); i++) begin
         clk(1);
         if (s_axi_awready_out === 1'h1 && ap) begin ap = 1'h0; s_axi_awvalid_in <= 1'h0; end
         if (s_axi_wready_out === 1'h1 && wp) begin wp = 1'h0; s_axi_wvalid_in <= 1'h0; end
      end
      tmo(i);
      for (i = 0; i < 40; i++) begin clk(1); if (s_axi_bvalid_out === 1'h1) break; end
      r = s_axi_bresp_out;
      s_axi_bready_in <= 1'h0;
      tmo(i);
      clk(1);
   endtask
   task rd(input logic [7:0] a);
      int i;
      s_axi_araddr_in <= a;
      s_axi_arvalid_in <= 1'h1;
      s_axi_rready_in <= 1'h1;
      for (i = 0; i < 40; i++) begin clk(1); if (s_axi_arready_out === 1'h1) break; end
      s_axi_arvalid_in <= 1'h0;
      tmo(i);
      for (i = 0; i < 40; i++) begin clk(1); if (s_axi_rvalid_out === 1'h1) break; end
      d = s_axi_rdata_out;
      r = s_axi_rresp_out;
      s_axi_rready_in <= 1'h0;
      tmo(i);
      clk(1);
   endtask
   task wv;
      int i;
      for (i = 0; i < 40; i++) begin clk(1); if (irq_valid_out === 1'h1) break; end
      tmo(i);
   endtask
   initial begin
      rst();
      foreach (rows[k]) begin
         unlock_in <= rows[k][12];
         wr(rows[k][31:24], rows[k][23:16]);
         chk(r, rows[k][1:0]);
         rd(rows[k][31:24]);
         chk(d, rows[k][11:4]);
         chk(r, rows[k][1:0]);
      end
      unlock_in <= 1'h0;
      $display("register table done");
      rst();
      for (int k = 0; k < 4; k++) begin rd(8'(k * 4)); chk(d, 32'h0); end
      $display("reset values done");
      irq_req_in <= 64'h221;
      wv();
      chk(irq_source_out, 8'h05);
      chk(irq_level_out, 2'h0);
      wr(8'h08, 8'h05);
      clk(3);
      chk(irq_source_out, 8'h09);
      wr(8'h00, 8'h01);
      wr(8'h08, 8'h00);
      ack_en <= 1'h1;
      clk(4);
      rd(8'h04);
      chk(d, 32'h01);
      rd(8'h08);
      chk(d, 32'h05);
      wr(8'h0c, 8'h09);
      clk(4);
      rd(8'h04);
      chk(d, 32'h03);
      irq_req_in <= 64'h222;
      clk(4);
      rd(8'h04);
      chk(d, 32'h83);
      irq_req_in <= 64'h0;
      ack_en <= 1'h0;
      foreach (ex[k]) begin
         ret_req <= 1'h1;
         clk(1);
         ret_req <= 1'h0;
         clk(3);
         rd(8'h04);
         chk(d, ex[k]);
      end
      $display("nesting done");
      unlock_in <= 1'h1;
      wr(8'h00, 8'h60);
      unlock_in <= 1'h0;
      irq_req_in <= 64'h100000;
      wv();
      chk(irq_vector_out, 8'h03);
      wr(8'h0c, 8'h14);
      clk(1);
      chk(irq_vector_out, 8'h02);
      chk(irq_level_out, 2'h1);
      chk(vectors_at_boot_out, 1'h1);
      boot_whole_flash_in <= 1'h1;
      clk(2);
      chk(vectors_at_boot_out, 1'h0);
      chk(reset_pc_out, 16'h0000);
      $display("compact table done");
      final_report;
   end
endmodule
